/* inc/vfa_params.svh */
`ifndef VFA_PARAMS_SVH
`define VFA_PARAMS_SVH
`define VFA_ADDR_EVEN 12'h040
`define VFA_ADDR_WC 12'h044
`define VFA_ADDR_ODD 12'h0C0
`define VFA_LC_RESET 8'h00
`define VFA_WC_RESET 8'hCF
`define VFA_LC_PEAK 7
`define VFA_LC_CGAIN 6
`define VFA_LC_LCR 5
`define VFA_LC_HF_HI 4
`define VFA_LC_HF_LO 3
`define VFA_WC_MAJ_HI 7
`define VFA_WC_MAJ_LO 6
`define VFA_WC_STEP_HI 5
`define VFA_LVL_3Q 8'hBF
`define VFA_LVL_HALF 8'h7F
`define VFA_LVL_1Q 8'h3F
`define VFA_GAIN_MIN 8'h20
`define VFA_GAIN_ONE 8'h40
`define VFA_GAIN_MAX 8'h80
`define VFA_HS_HALF 16'h1000
`define VFA_HS_QUARTER 16'h3000
`define VFA_HS_EIGHTH 16'h7000
`define VFA_CNT_W 20
`define VFA_TOT_W 16
`define VFA_RESP_OKAY 2'h0
`define VFA_RESP_SLVERR 2'h2
`endif

/* inc/vfa_pkg.sv */
`include "vfa_params.svh"
package vfa_pkg;
  // Low-pass choice, Gray ordered along the shrinking scale
  typedef enum logic [1:0] {
    VFA_LPF_NONE = 2'h0,
    VFA_LPF_CIF = 2'h1,
    VFA_LPF_QCIF = 2'h3,
    VFA_LPF_ICON = 2'h2
  } vfa_lpf_t;

  // Whole state of the control block apart from the reset synchroniser
  typedef struct packed {
    logic [7:0] even_lc;
    logic [7:0] odd_lc;
    logic [7:0] white_crush_raise_control;
    logic [7:0] act_lc;
    logic act_odd;
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [11:0] awaddr;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`VFA_CNT_W-1:0] below_cnt;
    logic [`VFA_CNT_W-1:0] above_cnt;
    logic [7:0] peak_luma;
    logic [7:0] last_peak;
    logic [`VFA_TOT_W-1:0] crush_total;
    logic crush_step;
    logic peak_en;
    logic [1:0] peak_sel;
    vfa_lpf_t lpf_sel;
    logic lpf_en;
    logic cgain_en;
    logic [7:0] chroma_gain;
    logic lcr_en;
    logic [7:0] maj_level;
  } vfa_state_t;
endpackage

/* core/vfa_ctrl.sv */
`timescale 1ns/10ps
`include "vfa_params.svh"
module vfa_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic field_start,
  input wire logic field_odd,
  input wire logic count_per_frame,
  input wire logic luma_decimation_control,
  input wire logic [15:0] hscale_ratio,
  input wire logic pixel_valid,
  input wire logic active_region,
  input wire logic [7:0] luma_in,
  input wire logic [7:0] chroma_gain_req,
  input wire logic agc_take,
  output logic luma_peak_en,
  output logic [1:0] peak_filter_sel,
  output vfa_pkg::vfa_lpf_t lpf_sel,
  output logic lpf_en,
  output logic chroma_gain_loop_enable,
  output logic [7:0] chroma_gain,
  output logic low_colour_removal_enable,
  output logic [7:0] majority_level,
  output logic [`VFA_TOT_W-1:0] crush_total,
  output logic crush_step_pulse
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  vfa_pkg::vfa_state_t s_reg;
  vfa_pkg::vfa_state_t s_next;
  logic [1:0] hf_bits;
  logic eval_now;
  logic [`VFA_TOT_W:0] sum_wide;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  assign hf_bits = s_reg.act_lc[`VFA_LC_HF_HI:`VFA_LC_HF_LO];
  // In frame mode the decision waits for the start of an even field
  assign eval_now = field_start && (!count_per_frame || !field_odd);
  assign sum_wide = {1'b0, s_reg.crush_total} + {{(`VFA_TOT_W-5){1'b0}}, s_reg.white_crush_raise_control[`VFA_WC_STEP_HI:0]};

  // Next-state logic for bus, field selection and crush statistics
  always_comb
  begin
    s_next = s_reg;
    s_next.crush_step = 1'b0;
    // Address and data are caught independently, in either order
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wlane0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    // The write lands once both halves are held and no response is pending
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = `VFA_RESP_OKAY;
      unique case ({s_reg.awaddr[11:2], 2'h0})
        `VFA_ADDR_EVEN:
          if (s_reg.wlane0)
            s_next.even_lc = {s_reg.wdata[7:3], 3'h0}; // Reserved bits kept clear
        `VFA_ADDR_ODD:
          if (s_reg.wlane0)
            s_next.odd_lc = {s_reg.wdata[7:3], 3'h0};
        `VFA_ADDR_WC:
          if (s_reg.wlane0)
            s_next.white_crush_raise_control = s_reg.wdata; // No field gating on this one
        default:
          s_next.bresp = `VFA_RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;
    // Read: one outstanding, data captured at the address handshake
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = `VFA_RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[11:2], 2'h0})
        `VFA_ADDR_EVEN: s_next.rdata[7:0] = s_reg.even_lc;
        `VFA_ADDR_ODD: s_next.rdata[7:0] = s_reg.odd_lc;
        `VFA_ADDR_WC: s_next.rdata[7:0] = s_reg.white_crush_raise_control;
        default: s_next.rresp = `VFA_RESP_SLVERR;
      endcase
    end
    // Field boundary picks the copy for the coming field
    if (field_start)
    begin
      s_next.act_lc = field_odd ? s_reg.odd_lc : s_reg.even_lc;
      s_next.act_odd = field_odd;
    end
    // AGC taking the total clears it; a same-cycle step still counts
    if (agc_take)
      s_next.crush_total = '0;
    if (eval_now)
    begin
      if (s_reg.below_cnt > s_reg.above_cnt)
      begin
        s_next.crush_step = 1'b1;
        // Step is unsigned; saturate rather than wrap
        if (agc_take)
          s_next.crush_total = {{(`VFA_TOT_W-6){1'b0}}, s_reg.white_crush_raise_control[`VFA_WC_STEP_HI:0]};
        else if (sum_wide[`VFA_TOT_W])
          s_next.crush_total = '1;
        else
          s_next.crush_total = sum_wide[`VFA_TOT_W-1:0];
      end
      s_next.below_cnt = '0;
      s_next.above_cnt = '0;
      s_next.last_peak = s_reg.peak_luma;
      s_next.peak_luma = 8'h00;
    end
    else if (pixel_valid && active_region)
    begin
      // Counters are wide enough for a full frame of active pixels
      if (luma_in < s_reg.maj_level)
        s_next.below_cnt = s_reg.below_cnt + 1'b1;
      else
        s_next.above_cnt = s_reg.above_cnt + 1'b1;
      if (luma_in > s_reg.peak_luma)
        s_next.peak_luma = luma_in;
    end
    // Comparison level; automatic tracks half the last field's peak, or half the last frame's peak in frame mode
    unique case (s_reg.white_crush_raise_control[`VFA_WC_MAJ_HI:`VFA_WC_MAJ_LO])
      2'h0: s_next.maj_level = `VFA_LVL_3Q;
      2'h1: s_next.maj_level = `VFA_LVL_HALF;
      2'h2: s_next.maj_level = `VFA_LVL_1Q;
      2'h3: s_next.maj_level = {1'b0, s_reg.last_peak[7:1]};
    endcase
    // Path controls follow the copy in force
    s_next.peak_en = s_reg.act_lc[`VFA_LC_PEAK];
    s_next.peak_sel = hf_bits;
    s_next.lpf_en = !s_reg.act_lc[`VFA_LC_PEAK] && !luma_decimation_control;
    unique case (hf_bits)
      2'h0:
        // Auto format from the horizontal scaling ratio
        if (hscale_ratio < `VFA_HS_HALF)
          s_next.lpf_sel = vfa_pkg::VFA_LPF_NONE;
        else if (hscale_ratio < `VFA_HS_QUARTER)
          s_next.lpf_sel = vfa_pkg::VFA_LPF_CIF;
        else if (hscale_ratio < `VFA_HS_EIGHTH)
          s_next.lpf_sel = vfa_pkg::VFA_LPF_QCIF;
        else
          s_next.lpf_sel = vfa_pkg::VFA_LPF_ICON;
      2'h1: s_next.lpf_sel = vfa_pkg::VFA_LPF_CIF;
      2'h2: s_next.lpf_sel = vfa_pkg::VFA_LPF_QCIF;
      2'h3: s_next.lpf_sel = vfa_pkg::VFA_LPF_ICON;
    endcase
    s_next.cgain_en = s_reg.act_lc[`VFA_LC_CGAIN];
    // Gain held inside 0.5..2.0 in Q2.6; unity when the loop is off
    if (!s_reg.act_lc[`VFA_LC_CGAIN])
      s_next.chroma_gain = `VFA_GAIN_ONE;
    else if (chroma_gain_req < `VFA_GAIN_MIN)
      s_next.chroma_gain = `VFA_GAIN_MIN;
    else if (chroma_gain_req > `VFA_GAIN_MAX)
      s_next.chroma_gain = `VFA_GAIN_MAX;
    else
      s_next.chroma_gain = chroma_gain_req;
    s_next.lcr_en = s_reg.act_lc[`VFA_LC_LCR];
  end

  // Single state register; clock enable freezes all of it, while the reset synchroniser keeps running
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.even_lc <= `VFA_LC_RESET;
      s_reg.odd_lc <= `VFA_LC_RESET;
      s_reg.white_crush_raise_control <= `VFA_WC_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.maj_level <= `VFA_LVL_HALF;
      s_reg.chroma_gain <= `VFA_GAIN_ONE;
    end
    else if (ce)
      s_reg <= s_next;
  end

  // Ports straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign luma_peak_en = s_reg.peak_en;
  assign peak_filter_sel = s_reg.peak_sel;
  assign lpf_sel = s_reg.lpf_sel;
  assign lpf_en = s_reg.lpf_en;
  assign chroma_gain_loop_enable = s_reg.cgain_en;
  assign chroma_gain = s_reg.chroma_gain;
  assign low_colour_removal_enable = s_reg.lcr_en;
  assign majority_level = s_reg.maj_level;
  assign crush_total = s_reg.crush_total;
  assign crush_step_pulse = s_reg.crush_step;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Field start loads the matching copy
  a_field_copy_odd: assert property (ce && field_start && field_odd |=> s_reg.act_lc == $past(s_reg.odd_lc))
    else $error("odd field did not load odd copy");
  a_field_copy_even: assert property (ce && field_start && !field_odd |=> s_reg.act_lc == $past(s_reg.even_lc))
    else $error("even field did not load even copy");
  // Peaking and low-pass are never both on
  a_peak_blocks_lpf: assert property (luma_peak_en |-> !lpf_en)
    else $error("low-pass enabled while peaking");
  a_gain_range: assert property (chroma_gain >= `VFA_GAIN_MIN && chroma_gain <= `VFA_GAIN_MAX)
    else $error("chroma gain out of range");
  a_gain_bypass: assert property (!chroma_gain_loop_enable |-> chroma_gain == `VFA_GAIN_ONE)
    else $error("chroma gain not unity when loop off");
  a_lcr_follow: assert property (ce |=> low_colour_removal_enable == $past(s_reg.act_lc[`VFA_LC_LCR]))
    else $error("low colour removal enable lags wrongly");
  a_decim_blocks: assert property (ce && luma_decimation_control |=> !lpf_en)
    else $error("filter enabled during decimation");
  a_auto_none: assert property (ce && hf_bits == 2'h0 && hscale_ratio < `VFA_HS_HALF |=> lpf_sel == vfa_pkg::VFA_LPF_NONE)
    else $error("auto mode picked a filter above half scale");
  a_reserved_clear: assert property (s_reg.even_lc[2:0] == 3'h0 && s_reg.odd_lc[2:0] == 3'h0)
    else $error("reserved loop bits set");
  a_level_quarter: assert property (ce && s_reg.white_crush_raise_control[7:6] == 2'h2 |=> majority_level == `VFA_LVL_1Q)
    else $error("quarter level not selected");
  a_crush_add: assert property (ce && eval_now && !agc_take && s_reg.below_cnt > s_reg.above_cnt && !sum_wide[`VFA_TOT_W]
    |=> crush_total == $past(sum_wide[`VFA_TOT_W-1:0]) && crush_step_pulse)
    else $error("crush step not accumulated");
  a_write_resp: assert property (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid && ce |=> s_axi_bvalid)
    else $error("write response missing");
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`include "vfa_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic count_per_frame = 1'b0;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, peak_filter_sel;
  logic field_start, field_odd, luma_decimation_control, pixel_valid, active_region, agc_take;
  logic [15:0] hscale_ratio;
  logic [7:0] luma_in, chroma_gain_req, chroma_gain, majority_level;
  logic luma_peak_en, lpf_en, chroma_gain_loop_enable, low_colour_removal_enable, crush_step_pulse;
  vfa_pkg::vfa_lpf_t lpf_sel;
  logic [`VFA_TOT_W-1:0] crush_total;
  int fail_count = 0;
  int samples_checked = 0;
  int pulses = 0;
  logic [15:0] hs [4] = '{16'h0800, 16'h2000, 16'h5000, 16'h8000};
  vfa_pkg::vfa_lpf_t lp [4] = '{vfa_pkg::VFA_LPF_NONE, vfa_pkg::VFA_LPF_CIF, vfa_pkg::VFA_LPF_QCIF,
    vfa_pkg::VFA_LPF_ICON};
  logic [7:0] lvl [3] = '{8'hBF, 8'h7F, 8'h3F};

  vfa_ctrl dut (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .field_start, .field_odd, .count_per_frame, .luma_decimation_control,
    .hscale_ratio, .pixel_valid, .active_region, .luma_in, .chroma_gain_req, .agc_take,
    .luma_peak_en, .peak_filter_sel, .lpf_sel, .lpf_en, .chroma_gain_loop_enable, .chroma_gain,
    .low_colour_removal_enable, .majority_level, .crush_total, .crush_step_pulse);

  // Free-running pixel clock
  always #50 clk = ~clk;

  // One-cycle step pulses are counted at the edge that samples them
  always @(posedge clk)
    if (crush_step_pulse === 1'b1) pulses++;

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 1000;
      end
    end
    if (n == 100) fail_count++;
  endtask

  // Read: rready held up until the answer is sampled
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    d = 32'h0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 1000;
      end
    end
    if (n == 100) fail_count++;
  endtask

  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    axw(a, {24'h0, d}, 4'hF, rs);
    `CHK(rs, `VFA_RESP_OKAY)
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    axr(a, rd, rs);
    `CHK(rd, e)
    `CHK(rs, er)
  endtask

  // Field start pulse; path outputs have settled when this returns
  task automatic fld(input logic odd);
    @(posedge clk);
    field_start <= 1'b1;
    field_odd <= odd;
    @(posedge clk);
    field_start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Eight active pixels at one luma level
  task automatic px(input logic [7:0] y);
    @(posedge clk);
    pixel_valid <= 1'b1;
    active_region <= 1'b1;
    luma_in <= y;
    repeat (8) @(posedge clk);
    pixel_valid <= 1'b0;
    active_region <= 1'b0;
  endtask

  task automatic results;
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about two hundred cycles
  initial
  begin
    #500000;
    fail_count++;
    results();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {field_start, field_odd, luma_decimation_control, pixel_valid, active_region, agc_take} = 6'h00;
    hscale_ratio = 16'h0800;
    luma_in = 8'h00;
    chroma_gain_req = 8'hFF;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`VFA_ADDR_EVEN, 32'h0, `VFA_RESP_OKAY);
    rchk(`VFA_ADDR_ODD, 32'h0, `VFA_RESP_OKAY);
    rchk(`VFA_ADDR_WC, 32'hCF, `VFA_RESP_OKAY);
    // Reserved bits written as ones come back as zero
    wreg(`VFA_ADDR_EVEN, 8'hFF);
    rchk(`VFA_ADDR_EVEN, 32'hF8, `VFA_RESP_OKAY);
    wreg(`VFA_ADDR_ODD, 8'h58);
    axw(12'h048, 32'hFF, 4'hF, rs);
    `CHK(rs, `VFA_RESP_SLVERR)
    rchk(12'h048, 32'h0, `VFA_RESP_SLVERR);
    // Even field: peaking, chroma loop clamped at 2.0, low colour removal on
    fld(1'b0);
    `CHK({luma_peak_en, peak_filter_sel, lpf_en}, 4'hE)
    `CHK({chroma_gain_loop_enable, chroma_gain}, 9'h180)
    `CHK(low_colour_removal_enable, 1'b1)
    // Odd field swaps in the other copy
    chroma_gain_req <= 8'h10;
    fld(1'b1);
    `CHK({luma_peak_en, lpf_sel, lpf_en}, {1'b0, vfa_pkg::VFA_LPF_ICON, 1'b1})
    `CHK({chroma_gain_loop_enable, chroma_gain}, 9'h120)
    `CHK(low_colour_removal_enable, 1'b0)
    luma_decimation_control <= 1'b1;
    fld(1'b1);
    `CHK(lpf_en, 1'b0)
    luma_decimation_control <= 1'b0;
    wreg(`VFA_ADDR_ODD, 8'h18);
    fld(1'b1);
    `CHK({chroma_gain_loop_enable, chroma_gain}, 9'h040)
    // Auto filter choice follows the scale ratio
    wreg(`VFA_ADDR_EVEN, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      hscale_ratio <= hs[i];
      fld(1'b0);
      `CHK({lpf_sel, lpf_en}, {lp[i], 1'b1})
    end
    // Every peaking code passes through
    for (int k = 0; k < 4; k++)
    begin
      wreg(`VFA_ADDR_EVEN, 8'h80 | (k[7:0] << 3));
      fld(1'b0);
      `CHK({luma_peak_en, peak_filter_sel}, {1'b1, k[1:0]})
    end
    // Fixed comparison levels
    for (int m = 0; m < 3; m++)
    begin
      wreg(`VFA_ADDR_WC, {m[1:0], 6'h3F});
      repeat (2) @(posedge clk);
      `CHK(majority_level, lvl[m])
    end
    // A refused byte lane, then crush accumulation of the largest step
    wreg(`VFA_ADDR_WC, 8'h3F);
    axw(`VFA_ADDR_WC, 32'h0, 4'hE, rs);
    rchk(`VFA_ADDR_WC, 32'h3F, `VFA_RESP_OKAY);
    `CHK(crush_total, 16'h0000)
    px(8'h10);
    fld(1'b0);
    `CHK(crush_total, 16'h003F)
    px(8'h10);
    fld(1'b1);
    px(8'hF0);
    fld(1'b0);
    `CHK(crush_total, 16'h007E)
    `CHK(pulses, 2)
    @(posedge clk);
    agc_take <= 1'b1;
    @(posedge clk);
    agc_take <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(crush_total, 16'h0000)
    // Automatic level is half the last field's peak, which was F0
    wreg(`VFA_ADDR_WC, 8'hC0);
    repeat (2) @(posedge clk);
    `CHK(majority_level, 8'h78)
    results();
  end
endmodule
